//--- rtl/mmiop_pin_drive.sv
// Registered pin driver with per-bit open-drain option
`timescale 1ns/1ps
module mmiop_pin_drive #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [W-1:0] drive_i,
   input wire logic [W-1:0] level_i,
   input wire logic [W-1:0] open_drain_i,
   output logic [W-1:0] pin_o,
   output logic [W-1:0] oe_n_o
);
   // Open drain: a one turns the driver off rather than pulling high
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_o <= '0;
         oe_n_o <= '1;
      end else begin
         pin_o <= level_i;
         oe_n_o <= ~(drive_i & (~open_drain_i | ~level_i));
      end
   end
endmodule : mmiop_pin_drive

//--- rtl/mmiop_pkg.sv
// Shared constants, modes and helpers for the mode-muxed I/O ports A to D
// Behaviour
// - Expanded and test modes: direction strobe high on reads, low on writes.
// - Single chip mode holds the direction strobe low.
// - Port E and port G top two pins are inputs only, never driven.
// - Ports B and C are general I/O only in single chip and bootstrap.
// - At reset general inputs float; latches hold reset state; function follows mode.
// - Port A reads return pins; writes go to latches; drive only outputs.
// - Port A latch writes never alter a pin owned by an output compare.
// - Port A inputs after reset; direction bit rules when alternate function off.
// - Port A shares pins with timer accumulator, compares and captures.
// - Port B is general I/O in single chip, high address in expanded.
// - Port B pull-ups are switched by the pull-up assignment bit.
// - Ports B and C drive latches only in single chip or bootstrap.
// - Port C is the data bus in expanded and test modes, general I/O otherwise.
// - Port C reads give pin for inputs, latch for outputs.
// - Port C out of reset: inputs in single/boot, data bus otherwise.
// - Port C open drain: zero drives low, one floats, no pull-high.
// - Port C open drain only takes effect in single chip mode.
// - Port D pins 5 to 2 serve SPI, pins 1 and 0 the async link.
// - Port D reads give pin or latch; latch drives general outputs only.
// - SPI open-drain bit covers pins 5 to 2, async bit pins 1 and 0.
// - Port D open drain allowed in single chip or expanded mode.
package mmiop_pkg;

   // ------------------------------------------------------------
   // Widths and reset values
   // ------------------------------------------------------------
   localparam int PORT_W = 8;
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'h00;
   localparam logic [7:0] ALL_ON = 8'hFF;
   localparam logic [7:0] ALL_OFF = 8'h00;

   // ------------------------------------------------------------
   // Port select codes on the write port
   // ------------------------------------------------------------
   localparam logic [1:0] SEL_TIMER = 2'h0;
   localparam logic [1:0] SEL_HIGH_ADDR = 2'h1;
   localparam logic [1:0] SEL_DATA_BUS = 2'h2;
   localparam logic [1:0] SEL_SERIAL = 2'h3;

   // ------------------------------------------------------------
   // Mode strap codes and settle count after reset release
   // ------------------------------------------------------------
   localparam logic [1:0] STRAP_BOOT = 2'h0;
   localparam logic [1:0] STRAP_TEST = 2'h1;
   localparam logic [1:0] STRAP_SINGLE = 2'h2;
   localparam logic [1:0] STRAP_EXPANDED = 2'h3;
   localparam logic [1:0] MODE_SETTLE = 2'h2;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CAP4_BIT = 3;
   localparam int PACC_BIT = 7;
   localparam int SPI_LO = 2;
   localparam int SPI_HI = 5;
   localparam int ASYNC_HI = 1;

   typedef enum logic [1:0] {
      MMIOP_SINGLE,
      MMIOP_EXPANDED,
      MMIOP_BOOT,
      MMIOP_TEST
   } mmiop_mode_t;

   // Strap decode, taken once after reset
   function automatic mmiop_mode_t decode_mode(input logic [1:0] strap);
      mmiop_mode_t m;
      if (strap == STRAP_BOOT) begin
         m = MMIOP_BOOT;
      end else if (strap == STRAP_TEST) begin
         m = MMIOP_TEST;
      end else if (strap == STRAP_SINGLE) begin
         m = MMIOP_SINGLE;
      end else begin
         m = MMIOP_EXPANDED;
      end
      return m;
   endfunction : decode_mode

   // Outputs read back the latch, inputs read the pin
   function automatic logic [7:0] readback(input logic [7:0] dir, input logic [7:0] latch,
                                           input logic [7:0] pin);
      return (dir & latch) | (~dir & pin);
   endfunction : readback

endpackage : mmiop_pkg

//--- rtl/mmiop_sync.sv
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
module mmiop_sync #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule : mmiop_sync

//--- rtl/mmiop_top.sv
// Mode-muxed I/O ports A to D with read/write strobe
`timescale 1ns/1ps
module mmiop_top (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [1:0] mode_strap_i,
   input wire logic wr_strobe_i,
   input wire logic [1:0] wr_sel_i,
   input wire logic wr_dir_i,
   input wire logic [7:0] wr_data_i,
   input wire logic bus_read_i,
   input wire logic bus_write_i,
   input wire logic [7:0] bus_addr_hi_i,
   input wire logic [7:0] bus_wdata_i,
   output logic [7:0] bus_rdata_o,
   output logic rw_o,
   input wire logic [7:3] timer_oc_en_i,
   input wire logic [7:3] timer_oc_lvl_i,
   input wire logic capture_four_sel_i,
   output logic pulse_accum_input_o,
   output logic capture_four_input_o,
   output logic [2:0] capture_input_o,
   input wire logic [5:0] serial_alt_en_i,
   input wire logic [5:0] serial_alt_out_i,
   output logic [5:0] serial_alt_in_o,
   input wire logic bus_port_open_drain_i,
   input wire logic spi_pins_open_drain_i,
   input wire logic async_pins_open_drain_i,
   input wire logic pullup_assign_reg_i,
   output logic high_addr_pullup_en_o,
   input wire logic [7:0] timer_port_pin_i,
   output logic [7:0] timer_port_pin_o,
   output logic [7:0] timer_port_oe_n_o,
   input wire logic [7:0] high_addr_port_pin_i,
   output logic [7:0] high_addr_port_pin_o,
   output logic [7:0] high_addr_port_oe_n_o,
   input wire logic [7:0] data_bus_port_pin_i,
   output logic [7:0] data_bus_port_pin_o,
   output logic [7:0] data_bus_port_oe_n_o,
   input wire logic [7:0] serial_port_pin_i,
   output logic [7:0] serial_port_pin_o,
   output logic [7:0] serial_port_oe_n_o,
   input wire logic [7:0] input_only_e_i,
   input wire logic [1:0] input_only_g_i,
   output logic [7:0] input_only_e_rdata_o,
   output logic [1:0] input_only_g_rdata_o,
   output logic [7:0] timer_port_rdata_o,
   output logic [7:0] high_addr_rdata_o,
   output logic [7:0] data_bus_rdata_o,
   output logic [7:0] serial_rdata_o
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] s_mode;
   logic [1:0] s_g;
   logic [7:0] s_e;
   logic [7:0] s_a;
   logic [7:0] s_b;
   logic [7:0] s_c;
   logic [7:0] s_d;

   // One bank for every pin that the port logic reads
   mmiop_sync #(.W(44)) u_sync (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .async_i({mode_strap_i, input_only_g_i, input_only_e_i, timer_port_pin_i,
                high_addr_port_pin_i, data_bus_port_pin_i, serial_port_pin_i}),
      .sync_o({s_mode, s_g, s_e, s_a, s_b, s_c, s_d})
   );

   // ------------------------------------------------------------
   // Operating mode capture
   // ------------------------------------------------------------
   mmiop_pkg::mmiop_mode_t mode_q;
   logic [1:0] mode_wait;
   logic mode_done;

   // Straps sampled once, after the synchroniser has filled
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_q <= mmiop_pkg::MMIOP_SINGLE;
         mode_wait <= 2'h0;
         mode_done <= 1'b0;
      end else if (!mode_done) begin
         if (mode_wait == mmiop_pkg::MODE_SETTLE) begin
            mode_q <= mmiop_pkg::decode_mode(s_mode);
            mode_done <= 1'b1;
         end else begin
            mode_wait <= mode_wait + 2'h1;
         end
      end
   end

   logic gp_mode;
   logic bus_mode;
   logic single_mode;
   logic serial_od_ok;

   // Mode qualifiers
   assign single_mode = (mode_q == mmiop_pkg::MMIOP_SINGLE);
   assign gp_mode = single_mode || (mode_q == mmiop_pkg::MMIOP_BOOT);
   assign bus_mode = !gp_mode;
   assign serial_od_ok = single_mode || (mode_q == mmiop_pkg::MMIOP_EXPANDED);

   // ------------------------------------------------------------
   // Latches and directions
   // ------------------------------------------------------------
   logic [7:0] timer_port_latch;
   logic [7:0] high_addr_port_latch;
   logic [7:0] data_bus_port_latch;
   logic [7:0] serial_port_latch;
   logic [7:0] timer_port_direction;
   logic [7:0] high_addr_port_direction;
   logic [7:0] data_bus_port_direction;
   logic [7:0] serial_port_direction;

   // Data latches; written in every mode even when pins are not driven
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer_port_latch <= mmiop_pkg::LATCH_RST;
         high_addr_port_latch <= mmiop_pkg::LATCH_RST;
         data_bus_port_latch <= mmiop_pkg::LATCH_RST;
         serial_port_latch <= mmiop_pkg::LATCH_RST;
      end else if (wr_strobe_i && !wr_dir_i) begin
         if (wr_sel_i == mmiop_pkg::SEL_TIMER) begin
            timer_port_latch <= wr_data_i;
         end else if (wr_sel_i == mmiop_pkg::SEL_HIGH_ADDR) begin
            high_addr_port_latch <= wr_data_i;
         end else if (wr_sel_i == mmiop_pkg::SEL_DATA_BUS) begin
            data_bus_port_latch <= wr_data_i;
         end else begin
            serial_port_latch <= wr_data_i;
         end
      end
   end

   // Direction bits, all inputs out of reset
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer_port_direction <= mmiop_pkg::DIR_RST;
         high_addr_port_direction <= mmiop_pkg::DIR_RST;
         data_bus_port_direction <= mmiop_pkg::DIR_RST;
         serial_port_direction <= mmiop_pkg::DIR_RST;
      end else if (wr_strobe_i && wr_dir_i) begin
         if (wr_sel_i == mmiop_pkg::SEL_TIMER) begin
            timer_port_direction <= wr_data_i;
         end else if (wr_sel_i == mmiop_pkg::SEL_HIGH_ADDR) begin
            high_addr_port_direction <= wr_data_i;
         end else if (wr_sel_i == mmiop_pkg::SEL_DATA_BUS) begin
            data_bus_port_direction <= wr_data_i;
         end else begin
            serial_port_direction <= wr_data_i;
         end
      end
   end

   // ------------------------------------------------------------
   // Drive selection per port
   // ------------------------------------------------------------
   logic [7:0] a_alt;
   logic [7:0] a_drive;
   logic [7:0] a_level;
   logic [7:0] b_drive;
   logic [7:0] b_level;
   logic [7:0] c_drive;
   logic [7:0] c_level;
   logic [7:0] c_od;
   logic [7:0] d_alt;
   logic [7:0] d_drive;
   logic [7:0] d_level;
   logic [7:0] d_od;

   // Port A: compares own bits 7..3; capture four takes bit 3 away from them
   always_comb begin
      a_alt = {timer_oc_en_i, 3'h0};
      a_alt[mmiop_pkg::CAP4_BIT] = timer_oc_en_i[mmiop_pkg::CAP4_BIT] && !capture_four_sel_i;
      a_drive = a_alt | (~a_alt & timer_port_direction);
      a_level = (a_alt & {timer_oc_lvl_i, 3'h0}) | (~a_alt & timer_port_latch);
   end

   // Port B: address byte in bus modes, latch under direction otherwise
   always_comb begin
      if (bus_mode) begin
         b_drive = mmiop_pkg::ALL_ON;
         b_level = bus_addr_hi_i;
      end else begin
         b_drive = high_addr_port_direction;
         b_level = high_addr_port_latch;
      end
   end

   // Port C: data bus drives only during write cycles so reads can land
   always_comb begin
      if (bus_mode) begin
         c_drive = bus_write_i ? mmiop_pkg::ALL_ON : mmiop_pkg::ALL_OFF;
         c_level = bus_wdata_i;
         c_od = mmiop_pkg::ALL_OFF;
      end else begin
         c_drive = data_bus_port_direction;
         c_level = data_bus_port_latch;
         c_od = (bus_port_open_drain_i && single_mode) ? mmiop_pkg::ALL_ON
                                                        : mmiop_pkg::ALL_OFF;
      end
   end

   // Port D: a serial peripheral claims a pin while its enable is up
   always_comb begin
      d_alt = {2'h0, serial_alt_en_i};
      d_drive = d_alt | (~d_alt & serial_port_direction);
      d_level = (d_alt & {2'h0, serial_alt_out_i}) | (~d_alt & serial_port_latch);
      d_od = mmiop_pkg::ALL_OFF;
      d_od[mmiop_pkg::SPI_HI:mmiop_pkg::SPI_LO] = {4{spi_pins_open_drain_i && serial_od_ok}};
      d_od[mmiop_pkg::ASYNC_HI:0] = {2{async_pins_open_drain_i && serial_od_ok}};
   end

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   mmiop_pin_drive #(.W(mmiop_pkg::PORT_W)) u_drv_a (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .drive_i(a_drive),
      .level_i(a_level),
      .open_drain_i(mmiop_pkg::ALL_OFF),
      .pin_o(timer_port_pin_o),
      .oe_n_o(timer_port_oe_n_o)
   );

   mmiop_pin_drive #(.W(mmiop_pkg::PORT_W)) u_drv_b (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .drive_i(b_drive),
      .level_i(b_level),
      .open_drain_i(mmiop_pkg::ALL_OFF),
      .pin_o(high_addr_port_pin_o),
      .oe_n_o(high_addr_port_oe_n_o)
   );

   // Open drain here drops the pull-high half of the driver
   mmiop_pin_drive #(.W(mmiop_pkg::PORT_W)) u_drv_c (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .drive_i(c_drive),
      .level_i(c_level),
      .open_drain_i(c_od),
      .pin_o(data_bus_port_pin_o),
      .oe_n_o(data_bus_port_oe_n_o)
   );

   mmiop_pin_drive #(.W(mmiop_pkg::PORT_W)) u_drv_d (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .drive_i(d_drive),
      .level_i(d_level),
      .open_drain_i(d_od),
      .pin_o(serial_port_pin_o),
      .oe_n_o(serial_port_oe_n_o)
   );

   // ------------------------------------------------------------
   // Read-back, strobe and peripheral inputs
   // ------------------------------------------------------------
   // Registered read values; one cycle after the synchroniser
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer_port_rdata_o <= mmiop_pkg::ALL_OFF;
         high_addr_rdata_o <= mmiop_pkg::ALL_OFF;
         data_bus_rdata_o <= mmiop_pkg::ALL_OFF;
         serial_rdata_o <= mmiop_pkg::ALL_OFF;
         bus_rdata_o <= mmiop_pkg::ALL_OFF;
         input_only_e_rdata_o <= mmiop_pkg::ALL_OFF;
         input_only_g_rdata_o <= 2'h0;
      end else begin
         timer_port_rdata_o <= s_a;
         high_addr_rdata_o <= s_b;
         data_bus_rdata_o <= mmiop_pkg::readback(data_bus_port_direction,
                                                 data_bus_port_latch, s_c);
         serial_rdata_o <= mmiop_pkg::readback(serial_port_direction,
                                               serial_port_latch, s_d);
         bus_rdata_o <= s_c;
         input_only_e_rdata_o <= s_e;
         input_only_g_rdata_o <= s_g;
      end
   end

   // Strobe and pull-up enable; pull-ups only matter while pins are general I/O
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rw_o <= 1'b0;
         high_addr_pullup_en_o <= 1'b0;
      end else begin
         rw_o <= bus_mode ? bus_read_i : 1'b0;
         high_addr_pullup_en_o <= pullup_assign_reg_i && gp_mode;
      end
   end

   // Timer and serial inputs see the synchronised pin levels
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pulse_accum_input_o <= 1'b0;
         capture_four_input_o <= 1'b0;
         capture_input_o <= 3'h0;
         serial_alt_in_o <= 6'h00;
      end else begin
         pulse_accum_input_o <= s_a[mmiop_pkg::PACC_BIT];
         capture_four_input_o <= s_a[mmiop_pkg::CAP4_BIT] && capture_four_sel_i;
         capture_input_o <= s_a[2:0];
         serial_alt_in_o <= s_d[5:0];
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_rw_single;
      @(posedge clk_i) disable iff (!arst_n_i) single_mode |=> !rw_o;
   endproperty
   a_rw_single: assert property (p_rw_single) else $error("strobe not low in single chip");

   property p_rw_bus;
      @(posedge clk_i) disable iff (!arst_n_i) (bus_mode && $stable(mode_q)) |=> rw_o == $past(bus_read_i);
   endproperty
   a_rw_bus: assert property (p_rw_bus) else $error("strobe does not follow bus read");

   property p_a_read;
      @(posedge clk_i) disable iff (!arst_n_i) $past(mode_done, 3) |-> timer_port_rdata_o == $past(timer_port_pin_i, 3);
   endproperty
   a_a_read: assert property (p_a_read) else $error("port A read is not pin level");

   property p_a_compare;
      @(posedge clk_i) disable iff (!arst_n_i) timer_oc_en_i[6] |=> timer_port_pin_o[6] == $past(timer_oc_lvl_i[6]) && !timer_port_oe_n_o[6];
   endproperty
   a_a_compare: assert property (p_a_compare) else $error("compare pin follows latch");

   property p_a_input;
      @(posedge clk_i) disable iff (!arst_n_i) (timer_oc_en_i == 5'h00 && timer_port_direction == mmiop_pkg::DIR_RST) |=> timer_port_oe_n_o == mmiop_pkg::ALL_ON;
   endproperty
   a_a_input: assert property (p_a_input) else $error("port A input pin driven");

   property p_c_bus_idle;
      @(posedge clk_i) disable iff (!arst_n_i) (bus_mode && !bus_write_i) |=> data_bus_port_oe_n_o == mmiop_pkg::ALL_ON;
   endproperty
   a_c_bus_idle: assert property (p_c_bus_idle) else $error("port C driven outside write");

   property p_c_od;
      @(posedge clk_i) disable iff (!arst_n_i) (single_mode && bus_port_open_drain_i) |=> (~data_bus_port_oe_n_o & data_bus_port_pin_o) == mmiop_pkg::ALL_OFF;
   endproperty
   a_c_od: assert property (p_c_od) else $error("port C open drain drove high");

   property p_c_read;
      @(posedge clk_i) disable iff (!arst_n_i) ##1 data_bus_rdata_o == (($past(data_bus_port_direction) & $past(data_bus_port_latch)) | (~$past(data_bus_port_direction) & $past(s_c)));
   endproperty
   a_c_read: assert property (p_c_read) else $error("port C read-back wrong");

   property p_d_od;
      @(posedge clk_i) disable iff (!arst_n_i) (spi_pins_open_drain_i && serial_od_ok) |=> (~serial_port_oe_n_o[5:2] & serial_port_pin_o[5:2]) == 4'h0;
   endproperty
   a_d_od: assert property (p_d_od) else $error("SPI pins open drain drove high");

endmodule : mmiop_top

//--- tb/mmiop_pins.sv
// Far-side pin model for one 8-bit port
`timescale 1ns/1ps
module mmiop_pins (
   input wire logic [7:0] pin_o_i,
   input wire logic [7:0] oe_n_i,
   input wire logic [7:0] ext_i,
   output logic [7:0] wire_o
);
   // Released bits show the outside level, never the last driven one
   assign wire_o = (~oe_n_i & pin_o_i) | (oe_n_i & ext_i);
endmodule : mmiop_pins

//--- tb/mmiop_test.sv
// Self-checking bench for the mode-muxed I/O ports
`timescale 1ns/1ps
module mmiop_test;
   // ----------
   // Wiring
   // ----------
   logic clk_i = 1'h0, arst_n_i = 1'h0, wr_strobe_i = 1'h0, wr_dir_i = 1'h0;
   logic bus_read_i = 1'h1, bus_write_i = 1'h0, capture_four_sel_i = 1'h0;
   logic bus_port_open_drain_i = 1'h0, spi_pins_open_drain_i = 1'h0;
   logic async_pins_open_drain_i = 1'h0, pullup_assign_reg_i = 1'h1;
   logic [1:0] mode_strap_i = 2'h0, wr_sel_i = 2'h0, input_only_g_i = 2'h0;
   logic [7:0] wr_data_i = 8'h00, bus_addr_hi_i = 8'h00, bus_wdata_i = 8'h00;
   logic [7:0] input_only_e_i = 8'h00, r, w, x;
   logic [7:3] timer_oc_en_i = 5'h00, timer_oc_lvl_i = 5'h00;
   logic [5:0] serial_alt_en_i = 6'h00, serial_alt_out_i = 6'h00;
   logic [7:0] ext_a = 8'h00, ext_b = 8'h00, ext_c = 8'h00, ext_d = 8'h00;
   logic [7:0] timer_port_pin_i, timer_port_pin_o, timer_port_oe_n_o, timer_port_rdata_o;
   logic [7:0] high_addr_port_pin_i, high_addr_port_pin_o, high_addr_port_oe_n_o;
   logic [7:0] data_bus_port_pin_i, data_bus_port_pin_o, data_bus_port_oe_n_o;
   logic [7:0] serial_port_pin_i, serial_port_pin_o, serial_port_oe_n_o;
   logic [7:0] data_bus_rdata_o, serial_rdata_o, input_only_e_rdata_o;
   logic rw_o, high_addr_pullup_en_o, pulse_accum_input_o, capture_four_input_o;
   logic [7:0] high_addr_rdata_o, bus_rdata_o;
   logic [1:0] input_only_g_rdata_o;
   logic [2:0] capture_input_o;
   logic [5:0] serial_alt_in_o;
   logic [7:0] obs [17];
   typedef struct {int k; logic [7:0] v;} mmiop_note_t;
   mmiop_note_t q[$];
   mmiop_note_t n;
   int num_errors = 0, tests_run = 0;

   mmiop_top mmiop_top_i (.clk_i, .arst_n_i, .mode_strap_i, .wr_strobe_i, .wr_sel_i, .wr_dir_i,
      .wr_data_i, .bus_read_i, .bus_write_i, .bus_addr_hi_i, .bus_wdata_i, .bus_rdata_o, .rw_o,
      .timer_oc_en_i, .timer_oc_lvl_i, .capture_four_sel_i, .pulse_accum_input_o,
      .capture_four_input_o, .capture_input_o, .serial_alt_en_i, .serial_alt_out_i,
      .serial_alt_in_o, .bus_port_open_drain_i, .spi_pins_open_drain_i,
      .async_pins_open_drain_i, .pullup_assign_reg_i, .high_addr_pullup_en_o, .timer_port_pin_i,
      .timer_port_pin_o, .timer_port_oe_n_o, .high_addr_port_pin_i, .high_addr_port_pin_o,
      .high_addr_port_oe_n_o, .data_bus_port_pin_i, .data_bus_port_pin_o, .data_bus_port_oe_n_o,
      .serial_port_pin_i, .serial_port_pin_o, .serial_port_oe_n_o, .input_only_e_i,
      .input_only_g_i, .input_only_e_rdata_o, .input_only_g_rdata_o, .timer_port_rdata_o,
      .high_addr_rdata_o, .data_bus_rdata_o, .serial_rdata_o);
   mmiop_pins mmiop_pins_a_i (.pin_o_i(timer_port_pin_o), .oe_n_i(timer_port_oe_n_o),
      .ext_i(ext_a), .wire_o(timer_port_pin_i));
   mmiop_pins mmiop_pins_b_i (.pin_o_i(high_addr_port_pin_o), .oe_n_i(high_addr_port_oe_n_o),
      .ext_i(ext_b), .wire_o(high_addr_port_pin_i));
   mmiop_pins mmiop_pins_c_i (.pin_o_i(data_bus_port_pin_o), .oe_n_i(data_bus_port_oe_n_o),
      .ext_i(ext_c), .wire_o(data_bus_port_pin_i));
   mmiop_pins mmiop_pins_d_i (.pin_o_i(serial_port_pin_o), .oe_n_i(serial_port_oe_n_o),
      .ext_i(ext_d), .wire_o(serial_port_pin_i));

   // Clock, 5 ns period
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   // ----------
   // Checking
   // ----------
   // Observed outputs by index; flags byte is pull-up enable then strobe
   always_comb obs = '{timer_port_pin_o, timer_port_oe_n_o, timer_port_rdata_o,
      high_addr_port_pin_o, high_addr_port_oe_n_o, data_bus_port_pin_o, data_bus_port_oe_n_o,
      data_bus_rdata_o, serial_port_pin_o, serial_port_oe_n_o, serial_rdata_o,
      {6'h00, high_addr_pullup_en_o, rw_o}, input_only_e_rdata_o, high_addr_rdata_o,
      bus_rdata_o, {pulse_accum_input_o, capture_four_input_o, input_only_g_rdata_o, 1'b0,
      capture_input_o}, {2'h0, serial_alt_in_o}};

   // Rising edge sees pre-edge values, so no race with the design flops
   always @(posedge clk_i) begin
      while (q.size() > 0) begin
         n = q.pop_front();
         tests_run++;
         if (obs[n.k] !== n.v) begin
            num_errors++;
            $display("BAD %0t out %0d got %h want %h", $time, n.k, obs[n.k], n.v);
         end
      end
   end

   task automatic exp(input int k, input logic [7:0] v);
      q.push_back('{k, v});
   endtask : exp

   // Pins follow one edge after a write, read-back three more
   task automatic settle();
      repeat (6) @(negedge clk_i);
   endtask : settle

   // Straps held through reset and well past release
   task automatic rst(input logic [1:0] m);
      @(negedge clk_i);
      arst_n_i = 1'h0;
      mode_strap_i = m;
      repeat (16) @(negedge clk_i);
      arst_n_i = 1'h1;
      settle();
   endtask : rst

   task automatic wr(input logic [1:0] s, input logic d, input logic [7:0] v);
      @(negedge clk_i);
      wr_strobe_i = 1'h1;
      wr_sel_i = s;
      wr_dir_i = d;
      wr_data_i = v;
      @(negedge clk_i);
      wr_strobe_i = 1'h0;
   endtask : wr

   task automatic results();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   // Watchdog: the sequence needs well under 1000 cycles
   initial begin
      #20000;
      num_errors++;
      results();
   end

   // ----------
   // Sequence
   // ----------
   initial begin
      void'($urandom(32'h0000_d98b));
      {ext_a, ext_b, ext_c, ext_d} = $urandom();
      {input_only_e_i, r, w, x} = $urandom();
      input_only_g_i = x[1:0];
      rst(mmiop_pkg::STRAP_SINGLE);
      exp(1, 8'hFF);
      exp(4, 8'hFF);
      exp(6, 8'hFF);
      exp(9, 8'hFF);
      exp(2, ext_a);
      exp(12, input_only_e_i);
      exp(11, 8'h02);
      exp(13, ext_b);
      exp(14, ext_c);
      exp(15, {ext_a[7], 1'b0, x[1:0], 1'b0, ext_a[2:0]});
      exp(16, {2'h0, ext_d[5:0]});
      wr(mmiop_pkg::SEL_TIMER, 1'h1, 8'hFF);
      wr(mmiop_pkg::SEL_TIMER, 1'h0, r);
      settle();
      exp(1, 8'h00);
      exp(0, r);
      exp(2, r);
      timer_oc_en_i = 5'h1F;
      timer_oc_lvl_i = x[4:0];
      wr(mmiop_pkg::SEL_TIMER, 1'h0, ~r);
      settle();
      exp(0, {x[4:0], ~r[2:0]});
      capture_four_sel_i = 1'h1;
      settle();
      exp(0, {x[4:1], ~r[3:0]});
      exp(15, {x[4], ~r[3], x[1:0], 1'b0, ~r[2:0]});
      wr(mmiop_pkg::SEL_HIGH_ADDR, 1'h1, 8'h0F);
      wr(mmiop_pkg::SEL_DATA_BUS, 1'h1, 8'hF0);
      wr(mmiop_pkg::SEL_DATA_BUS, 1'h0, r);
      settle();
      exp(4, 8'hF0);
      exp(6, 8'h0F);
      exp(7, (r & 8'hF0) | (ext_c & 8'h0F));
      bus_port_open_drain_i = 1'h1;
      spi_pins_open_drain_i = 1'h1;
      wr(mmiop_pkg::SEL_DATA_BUS, 1'h1, 8'hFF);
      wr(mmiop_pkg::SEL_SERIAL, 1'h1, 8'hFF);
      wr(mmiop_pkg::SEL_SERIAL, 1'h0, w);
      settle();
      exp(6, r);
      exp(9, w & 8'h3C);
      exp(10, w);
      spi_pins_open_drain_i = 1'h0;
      async_pins_open_drain_i = 1'h1;
      settle();
      exp(9, w & 8'h03);
      async_pins_open_drain_i = 1'h0;
      serial_alt_en_i = 6'h3F;
      serial_alt_out_i = x[7:2];
      settle();
      exp(8, {w[7:6], x[7:2]});
      serial_alt_en_i = 6'h00;
      bus_addr_hi_i = x;
      rst(mmiop_pkg::STRAP_EXPANDED);
      exp(4, 8'h00);
      exp(3, x);
      exp(6, 8'hFF);
      exp(11, 8'h01);
      wr(mmiop_pkg::SEL_DATA_BUS, 1'h1, 8'hFF);
      wr(mmiop_pkg::SEL_SERIAL, 1'h1, 8'hFF);
      wr(mmiop_pkg::SEL_SERIAL, 1'h0, r);
      settle();
      exp(6, 8'hFF);
      bus_read_i = 1'h0;
      bus_write_i = 1'h1;
      bus_wdata_i = w;
      spi_pins_open_drain_i = 1'h1;
      async_pins_open_drain_i = 1'h1;
      settle();
      exp(5, w);
      exp(6, 8'h00);
      exp(11, 8'h00);
      exp(9, r & 8'h3F);
      bus_read_i = 1'h1;
      rst(mmiop_pkg::STRAP_TEST);
      exp(11, 8'h01);
      rst(mmiop_pkg::STRAP_BOOT);
      wr(mmiop_pkg::SEL_DATA_BUS, 1'h1, 8'hFF);
      wr(mmiop_pkg::SEL_DATA_BUS, 1'h0, 8'hFF);
      settle();
      exp(6, 8'h00);
      exp(11, 8'h02);
      settle();
      results();
   end
endmodule : mmiop_test
